// [rtl/fsw_defs.svh]
// fieldbus status word: bit positions, register location, reset values
// assumes inclusion by bare name from the package and design files
`ifndef FSW_DEFS_SVH
`define FSW_DEFS_SVH

`define FSW_BIT_SWITCH_ON_READY  0
`define FSW_BIT_MOD_READY        1
`define FSW_BIT_RUNNING          2
`define FSW_BIT_FAULT            3
`define FSW_BIT_QUICK_STOP_N     5
`define FSW_BIT_WARNING          7
`define FSW_BIT_CTRL_PLACE       9
`define FSW_BIT_RUN_ENABLE       11
`define FSW_BIT_WATCHDOG         15
`define FSW_RSVD_MASK            16'h7550
`define FSW_HOLD_REG_LOCATION    16'h000A
`define FSW_RESET_WORD           16'h0020
`define FSW_STATION_COUNT        1

`endif

// [rtl/fsw_pkg.sv]
// fieldbus status word types
// assumes fsw_defs.svh on the include path
`include "fsw_defs.svh"
package fsw_pkg;
    typedef struct packed {
        logic switch_on_ready_flag;
        logic modulation_ready_flag;
        logic running;
        logic fault;
        logic quick_stop;
        logic warning;
        logic fieldbus_control_place_flag;
        logic run_enable;
        logic watchdog;
    } fsw_flags_t;
endpackage

// [rtl/fsw_status_word.sv]
// fieldbus status word register bank
// assumes flags from converter logic on ref_clk_i; run enable from a pin
//
// What this block does
// - bit 0 is 1 when the converter is switch_on_ready_flag.
// - bit 1 is 1 when the converter is ready to begin modulating.
// - bit 2 is 1 while the converter modulates.
// - bit 3 is 1 while any fault is active.
// - bit 5 is 0 while quick stop is in effect, 1 otherwise.
// - bit 7 is 1 while any warning is active.
// - bit 9 is 1 when the fieldbus is the control place.
// - bit 11 follows the dedicated run-enable input.
// - bit 15 carries the outgoing watchdog bit.
// - the two ethernet ports act as one station with one address pair.
// - ring networks use parallel redundancy at layer 2.
// - the word is one 16-bit holding register.
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defs.svh"
module fsw_status_word
    import fsw_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire fsw_flags_t flags_i,
    input  wire logic       run_enable_pin_i,
    input  wire logic       snapshot_i,
    output var  logic [15:0] converter_state_flags_o,
    output var  logic [15:0] hold_reg_location_o,
    output var  logic       snapshot_done_o
);

    logic [2:0]  run_en_sync_q;
    logic        run_en_q;
    logic        run_en_agree;
    logic [15:0] word_d;
    logic [15:0] converter_state_flags_q;
    logic        snapshot_done_q;
    logic [15:0] hold_reg_location_q;

    function automatic logic [15:0] fsw_pack(input fsw_flags_t f, input logic re);
        logic [15:0] w;
        w = 16'h0000;
        w[`FSW_BIT_SWITCH_ON_READY] = f.switch_on_ready_flag;
        w[`FSW_BIT_MOD_READY]       = f.modulation_ready_flag;
        w[`FSW_BIT_RUNNING]         = f.running;
        w[`FSW_BIT_FAULT]           = f.fault;
        w[`FSW_BIT_QUICK_STOP_N]    = ~f.quick_stop;
        w[`FSW_BIT_WARNING]         = f.warning;
        w[`FSW_BIT_CTRL_PLACE]      = f.fieldbus_control_place_flag;
        w[`FSW_BIT_RUN_ENABLE]      = re;
        w[`FSW_BIT_WATCHDOG]        = f.watchdog;
        return w;
    endfunction

    // run enable pin: three stages, change taken when last two agree
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_en_sync_q <= 3'h0;
        end else begin
            run_en_sync_q <= {run_en_sync_q[1:0], run_enable_pin_i};
        end
    end

    // a pulse seen by fewer than two late stages never reaches the word
    assign run_en_agree = (run_en_sync_q[1] == run_en_sync_q[2]);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_en_q <= 1'b0;
        end else if (run_en_agree) begin
            run_en_q <= run_en_sync_q[2];
        end
    end

    assign word_d = fsw_pack(flags_i, run_en_q) & ~`FSW_RSVD_MASK;

    // whole word captured in one edge when snapshot is requested
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            converter_state_flags_q <= `FSW_RESET_WORD;
            snapshot_done_q         <= 1'b0;
            hold_reg_location_q     <= 16'h0000;
        end else begin
            // word moves only here, so duplicate ring frames read alike
            if (snapshot_i) begin
                converter_state_flags_q <= word_d;
            end
            snapshot_done_q     <= snapshot_i;
            // one station, one register image behind both ports
            hold_reg_location_q <= `FSW_HOLD_REG_LOCATION;
        end
    end

    assign converter_state_flags_o = converter_state_flags_q;
    assign hold_reg_location_o     = hold_reg_location_q;
    assign snapshot_done_o         = snapshot_done_q;

    // checks
    sequence s_snap;
        snapshot_i ##1 snapshot_done_o;
    endsequence

    // pin held at one level through the whole filter
    sequence s_pin_high;
        run_enable_pin_i [*4];
    endsequence

    sequence s_pin_low;
        (!run_enable_pin_i) [*4];
    endsequence

    sequence s_two_snaps;
        snapshot_i ##1 snapshot_i;
    endsequence

    property p_fault;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_FAULT] == $past(flags_i.fault);
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit mismatch");

    property p_ready;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[1:0] ==
            {$past(flags_i.modulation_ready_flag), $past(flags_i.switch_on_ready_flag)};
    endproperty
    a_ready: assert property (p_ready) else $error("ready bits mismatch");

    property p_run;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_RUNNING] == $past(flags_i.running);
    endproperty
    a_run: assert property (p_run) else $error("running bit mismatch");

    property p_qstop;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_QUICK_STOP_N] != $past(flags_i.quick_stop);
    endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop not inverted");

    property p_warn;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_WARNING] == $past(flags_i.warning);
    endproperty
    a_warn: assert property (p_warn) else $error("warning bit mismatch");

    property p_place;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_CTRL_PLACE] ==
            $past(flags_i.fieldbus_control_place_flag);
    endproperty
    a_place: assert property (p_place) else $error("control place mismatch");

    property p_runen;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_pin_high ##1 snapshot_i |=> converter_state_flags_o[`FSW_BIT_RUN_ENABLE];
    endproperty
    a_runen: assert property (p_runen) else $error("run enable not seen");

    property p_wdog;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_WATCHDOG] == $past(flags_i.watchdog);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog bit mismatch");

    property p_rsvd;
        @(posedge ref_clk_i) disable iff (rst_i)
        (converter_state_flags_o & `FSW_RSVD_MASK) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        !snapshot_i |=> $stable(converter_state_flags_o);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed without snapshot");

    property p_done;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |-> s_snap;
    endproperty
    a_done: assert property (p_done) else $error("snapshot done missing");

    property p_runen_off;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_pin_low ##1 snapshot_i |=> !converter_state_flags_o[`FSW_BIT_RUN_ENABLE];
    endproperty
    a_runen_off: assert property (p_runen_off) else $error("run enable seen while pin low");

    property p_runen_bit;
        @(posedge ref_clk_i) disable iff (rst_i)
        snapshot_i |=> converter_state_flags_o[`FSW_BIT_RUN_ENABLE] == $past(run_en_q);
    endproperty
    a_runen_bit: assert property (p_runen_bit) else $error("run enable bit mismatch");

    property p_filter;
        @(posedge ref_clk_i) disable iff (rst_i)
        $changed(run_en_q) |-> $past(run_en_agree) && (run_en_q == $past(run_en_sync_q[2]));
    endproperty
    a_filter: assert property (p_filter) else $error("run enable moved without agreement");

    property p_loc;
        @(posedge ref_clk_i) disable iff (rst_i)
        !$past(rst_i) |-> hold_reg_location_o == `FSW_HOLD_REG_LOCATION;
    endproperty
    a_loc: assert property (p_loc) else $error("register location wrong");

    property p_done_only;
        @(posedge ref_clk_i) disable iff (rst_i)
        !snapshot_i |=> !snapshot_done_o;
    endproperty
    a_done_only: assert property (p_done_only) else $error("done without snapshot");

    property p_pair;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_two_snaps |=> snapshot_done_o && converter_state_flags_o[`FSW_BIT_FAULT] == $past(flags_i.fault);
    endproperty
    a_pair: assert property (p_pair) else $error("second snapshot not taken");

endmodule
`default_nettype wire

// [verif/fsw_plc_model.sv]
// fieldbus master model: asks for a snapshot, then reads the status word
// assumes the block answers with a done pulse one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module fsw_plc_model (
    input  wire logic        clk_i,
    input  wire logic        poll_i,
    input  wire logic        done_i,
    input  wire logic [15:0] word_i,
    output var  logic        snap_o,
    output var  logic [15:0] read_o,
    output var  logic        valid_o
);
    initial begin
        snap_o = 1'b0;
        read_o = 16'h0000;
        valid_o = 1'b0;
    end
    // one request per poll, spaced by the bench
    always @(posedge clk_i) begin
        snap_o <= poll_i;
        valid_o <= done_i;
        if (done_i) begin
            read_o <= word_i; // whole 16-bit register
        end
    end
endmodule
`default_nettype wire

// [verif/fsw_status_word_tb_top.sv]
// random and corner flag sets, read back through the master model
// assumes the design package and header are compiled first
`timescale 1ns/1ps
`default_nettype none
module fsw_status_word_tb_top;
    import fsw_pkg::*;
    logic        ref_clk_i, rst_i, pin, poll, snap, done, valid;
    fsw_flags_t  flags;
    logic [15:0] word, loc, rd;
    int          err_total, tests_run;
    fsw_status_word DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .flags_i(flags), .run_enable_pin_i(pin),
        .snapshot_i(snap), .converter_state_flags_o(word), .hold_reg_location_o(loc), .snapshot_done_o(done));
    fsw_plc_model plc (.clk_i(ref_clk_i), .poll_i(poll), .done_i(done), .word_i(word), .snap_o(snap),
        .read_o(rd), .valid_o(valid));
    function automatic logic [15:0] exp_word(input fsw_flags_t f, input logic p);
        exp_word = {f.watchdog, 3'b000, p, 1'b0, f.fieldbus_control_place_flag, 1'b0, f.warning, 1'b0,
            ~f.quick_stop, 1'b0, f.fault, f.running, f.modulation_ready_flag, f.switch_on_ready_flag};
    endfunction
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk_bit(input string name, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run(input fsw_flags_t f, input logic p);
        logic [15:0] e;
        e = exp_word(f, p);
        @(posedge ref_clk_i);
        #1 flags = f;
        pin = p;
        repeat (6) @(posedge ref_clk_i);
        #1 poll = 1'b1;
        @(posedge ref_clk_i);
        #1 poll = 1'b0;
        @(posedge ref_clk_i);
        #1 flags = 9'($urandom);
        chk_bit("done pulse", 1'b1, done);
        chk("fresh word", e, word);
        for (int n = 0; n < 8 && valid !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        chk_bit("valid", 1'b1, valid);
        chk("word", e, rd);
        chk("held word", e, word);
        chk_bit("done", 1'b0, done);
        chk("location", 16'h000A, loc);
    endtask
    // one-cycle pulse on the run enable pin must be filtered out
    task automatic glitch(input fsw_flags_t f);
        @(posedge ref_clk_i);
        #1 pin = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1 pin = 1'b1;
        @(posedge ref_clk_i);
        #1 pin = 1'b0;
        run(f, 1'b0);
    endtask
    // back-to-back snapshots: the second capture replaces the first whole
    task automatic burst(input fsw_flags_t f1, input fsw_flags_t f2);
        @(posedge ref_clk_i);
        #1 flags = f1;
        pin = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1 poll = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 poll = 1'b0;
        flags = f2;
        chk("first of pair", exp_word(f1, 1'b0), word);
        @(posedge ref_clk_i);
        #1 flags = 9'($urandom);
        chk("second of pair", exp_word(f2, 1'b0), word);
        chk_bit("done held", 1'b1, done);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("pair read", exp_word(f2, 1'b0), rd);
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    initial begin
        rst_i = 1'b1;
        pin = 1'b0;
        poll = 1'b0;
        flags = '0;
        err_total = 0;
        tests_run = 0;
        void'($urandom(32'hF422));
        repeat (5) @(posedge ref_clk_i);
        #1 chk("reset word", 16'h0020, word);
        chk("reset location", 16'h0000, loc);
        chk_bit("reset done", 1'b0, done);
        rst_i = 1'b0;
        @(posedge ref_clk_i);
        #1 chk("location after reset", 16'h000A, loc);
        run('0, 1'b0);
        run('1, 1'b1);
        for (int i = 0; i < 40; i++) begin
            run(9'($urandom), 1'($urandom));
        end
        glitch(9'($urandom));
        burst('0, '1);
        burst(9'($urandom), 9'($urandom));
        @(posedge ref_clk_i);
        #1 rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 chk("reset word again", 16'h0020, word);
        chk("location in reset", 16'h0000, loc);
        chk_bit("done in reset", 1'b0, done);
        rst_i = 1'b0;
        @(posedge ref_clk_i);
        #1 chk("location after second reset", 16'h000A, loc);
        chk("word after second reset", 16'h0020, word);
        run(9'($urandom), 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
